// ### verilog/swse_map.svh
// Purpose: constants for the store word/string execution block
// Assumes: 32-bit core, little-endian bit numbering (bit 31 is the msb)
// Notes: register offsets are byte addresses on the axi4-lite port
`ifndef SWSE_MAP_SVH
`define SWSE_MAP_SVH
`define SWSE_OFF_INSN 8'h00
`define SWSE_OFF_SRC 8'h04
`define SWSE_OFF_BASE 8'h08
`define SWSE_OFF_INDEX 8'h0C
`define SWSE_OFF_XER 8'h10
`define SWSE_OFF_CTRL 8'h14
`define SWSE_OFF_STAT 8'h18
`define SWSE_OFF_ADDR 8'h1C
`define SWSE_OFF_WDATA 8'h20
`define SWSE_OFF_CR0 8'h24
`define SWSE_OFF_SNOOP 8'h28
`define SWSE_OP_PRIMARY 6'h1F
`define SWSE_OP_STW 6'h24
`define SWSE_XO_STSWX 10'h295
`define SWSE_XO_STWBRX 10'h296
`define SWSE_XO_STWCX 10'h096
`define SWSE_CTRL_GO 0
`define SWSE_CTRL_RESV 1
`define SWSE_CTRL_ACK 2
`define SWSE_XER_SO 31
`define SWSE_RESP_OKAY 2'h0
`define SWSE_RESP_SLVERR 2'h2
`endif

// ### verilog/swse_pkg.sv
// Purpose: types for the store word/string execution block
// Assumes: constants live in swse_map.svh
// Notes: none
package swse_pkg;
	typedef enum logic [2:0] {
		SWSE_OP_NONE = 3'b000,
		SWSE_OP_STRING = 3'b001,
		SWSE_OP_DISP = 3'b010,
		SWSE_OP_BREV = 3'b011,
		SWSE_OP_COND = 3'b100
	} swse_op_t;
	typedef enum logic [1:0] {
		SWSE_IDLE = 2'b00,
		SWSE_EMIT = 2'b01,
		SWSE_WAIT = 2'b10
	} swse_state_t;
	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} swse_store_t;
endpackage

// ### verilog/swse_exec.sv
// Purpose: store word/string execution with an axi4-lite register front end
// Assumes: storage takes one store per cycle on st_*, answers with st_ready
// Notes: string data is read from operand registers via a word index port
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "swse_map.svh"
module swse_exec
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [4:0] regfile_idx,
	input wire logic [31:0] regfile_data,
	output swse_pkg::swse_store_t st_req,
	input wire logic st_ready,
	output logic mq_undef
);
	function automatic logic [31:0] ea_calc(input logic [4:0] ra, input logic [31:0] b,
		input logic [31:0] off);
		ea_calc = (ra == 5'h00) ? off : b + off;
	endfunction

	// ==========================================================
	// bus slave
	logic [31:0] insn_q, insn_d, src_q, src_d, base_q, base_d, idx_q, idx_d, xer_q, xer_d;
	logic resv_q, resv_d, busy_q, busy_d, go;
	logic [3:0] cr0_q, cr0_d;
	logic [31:0] laddr_q, laddr_d, ldata_q, ldata_d, raddr_q, raddr_d;
	logic aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
	logic [7:0] awa_q, awa_d;
	logic [31:0] wd_q, wd_d, rd_q, rd_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic wr_fire;
	logic [31:0] wr_word;
	assign s_axi_awready = !aw_q && !b_q;
	assign s_axi_wready = !w_q && !b_q;
	assign s_axi_bvalid = b_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = !r_q;
	assign s_axi_rvalid = r_q;
	assign s_axi_rdata = rd_q;
	assign s_axi_rresp = rresp_q;
	always_comb
	begin
		aw_d = aw_q;
		w_d = w_q;
		b_d = b_q;
		awa_d = awa_q;
		wd_d = wd_q;
		bresp_d = bresp_q;
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_d = 1'b1;
			awa_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_d = 1'b1;
			for (int i = 0; i < 4; i++)
				wd_d[i*8 +: 8] = s_axi_wstrb[i] ? s_axi_wdata[i*8 +: 8] : 8'h00;
		end
		wr_fire = aw_q && w_q;
		wr_word = wd_q;
		if (wr_fire)
		begin
			aw_d = 1'b0;
			w_d = 1'b0;
			b_d = 1'b1;
			bresp_d = (awa_q <= `SWSE_OFF_SNOOP && awa_q[1:0] == 2'h0) ? `SWSE_RESP_OKAY
				: `SWSE_RESP_SLVERR;
		end
		if (b_q && s_axi_bready)
			b_d = 1'b0;
		r_d = r_q;
		rd_d = rd_q;
		rresp_d = rresp_q;
		if (s_axi_arvalid && s_axi_arready)
		begin
			r_d = 1'b1;
			rresp_d = `SWSE_RESP_OKAY;
			unique case (s_axi_araddr)
				`SWSE_OFF_INSN: rd_d = insn_q;
				`SWSE_OFF_SRC: rd_d = src_q;
				`SWSE_OFF_BASE: rd_d = base_q;
				`SWSE_OFF_INDEX: rd_d = idx_q;
				`SWSE_OFF_XER: rd_d = xer_q;
				`SWSE_OFF_STAT: rd_d = {29'h0, mq_undef, resv_q, busy_q};
				`SWSE_OFF_ADDR: rd_d = laddr_q;
				`SWSE_OFF_WDATA: rd_d = ldata_q;
				`SWSE_OFF_CR0: rd_d = {28'h0, cr0_q};
				default:
				begin
					rd_d = 32'h0;
					rresp_d = `SWSE_RESP_SLVERR;
				end
			endcase
		end
		else if (r_q && s_axi_rready)
			r_d = 1'b0;
	end

	// ==========================================================
	// decode and execute
	swse_pkg::swse_state_t st_q, st_d;
	swse_pkg::swse_op_t op_q, op_d, dec;
	logic [6:0] left_q, left_d, cnt;
	logic [1:0] bsel_q, bsel_d;
	logic [4:0] reg_q, reg_d;
	swse_pkg::swse_store_t req_q, req_d;
	logic mq_q, mq_d;
	logic [31:0] ea, srcw;
	assign regfile_idx = reg_q;
	assign st_req = req_q;
	assign mq_undef = mq_q;
	assign cnt = xer_q[6:0];
	always_comb
	begin
		dec = swse_pkg::SWSE_OP_NONE;
		if (insn_q[31:26] == `SWSE_OP_STW)
			dec = swse_pkg::SWSE_OP_DISP;
		else if (insn_q[31:26] == `SWSE_OP_PRIMARY)
		begin
			if (insn_q[10:1] == `SWSE_XO_STSWX)
				dec = swse_pkg::SWSE_OP_STRING;
			else if (insn_q[10:1] == `SWSE_XO_STWBRX)
				dec = swse_pkg::SWSE_OP_BREV;
			else if (insn_q[10:1] == `SWSE_XO_STWCX && insn_q[0])
				dec = swse_pkg::SWSE_OP_COND;
		end
		if (dec == swse_pkg::SWSE_OP_DISP)
			ea = ea_calc(insn_q[20:16], base_q, {{16{insn_q[15]}}, insn_q[15:0]});
		else
			ea = ea_calc(insn_q[20:16], base_q, idx_q);
		srcw = src_q;
	end
	always_comb
	begin
		go = 1'b0;
		insn_d = insn_q;
		src_d = src_q;
		base_d = base_q;
		idx_d = idx_q;
		xer_d = xer_q;
		resv_d = resv_q;
		mq_d = mq_q;
		if (wr_fire)
		begin
			unique case (awa_q)
				`SWSE_OFF_INSN: insn_d = wr_word;
				`SWSE_OFF_SRC: src_d = wr_word;
				`SWSE_OFF_BASE: base_d = wr_word;
				`SWSE_OFF_INDEX: idx_d = wr_word;
				`SWSE_OFF_XER: xer_d = wr_word;
				`SWSE_OFF_CTRL:
				begin
					go = wr_word[`SWSE_CTRL_GO] && !busy_q;
					if (wr_word[`SWSE_CTRL_RESV])
						resv_d = 1'b1;
					if (wr_word[`SWSE_CTRL_ACK])
						mq_d = 1'b0;
				end
				// any other agent touching storage kills the reservation
				`SWSE_OFF_SNOOP: resv_d = 1'b0;
				default: ;
			endcase
		end
		st_d = st_q;
		op_d = op_q;
		left_d = left_q;
		bsel_d = bsel_q;
		reg_d = reg_q;
		req_d = req_q;
		busy_d = busy_q;
		cr0_d = cr0_q;
		laddr_d = laddr_q;
		ldata_d = ldata_q;
		raddr_d = raddr_q;
		unique case (st_q)
			swse_pkg::SWSE_IDLE:
			if (go)
			begin
				op_d = dec;
				busy_d = 1'b1;
				laddr_d = ea;
				unique case (dec)
					swse_pkg::SWSE_OP_DISP:
					begin
						req_d = '{1'b1, ea, srcw, 4'hF};
						ldata_d = srcw;
						st_d = swse_pkg::SWSE_WAIT;
					end
					swse_pkg::SWSE_OP_BREV:
					begin
						ldata_d = {srcw[7:0], srcw[15:8], srcw[23:16], srcw[31:24]};
						req_d = '{1'b1, ea, ldata_d, 4'hF};
						st_d = swse_pkg::SWSE_WAIT;
					end
					swse_pkg::SWSE_OP_COND:
					begin
						// unaligned address stores anyway; result undefined by contract
						if (resv_q)
						begin
							req_d = '{1'b1, ea, srcw, 4'hF};
							ldata_d = srcw;
							resv_d = 1'b0;
							st_d = swse_pkg::SWSE_WAIT;
						end
						else
						begin
							busy_d = 1'b0;
						end
						cr0_d = {1'b0, 1'b0, resv_q, xer_q[`SWSE_XER_SO]};
					end
					swse_pkg::SWSE_OP_STRING:
					begin
						mq_d = 1'b1;
						raddr_d = ea;
						left_d = cnt;
						bsel_d = 2'h0;
						reg_d = insn_q[25:21];
						if (cnt == 7'h00)
							busy_d = 1'b0;
						else
							st_d = swse_pkg::SWSE_EMIT;
					end
					default: busy_d = 1'b0;
				endcase
			end
			swse_pkg::SWSE_EMIT:
			begin
				// one byte per store keeps lane math trivial; string stores are rare
				req_d = '{1'b1, raddr_q, {4{regfile_data[31 - 8*bsel_q -: 8]}},
					4'h8 >> raddr_q[1:0]};
				ldata_d = {24'h0, regfile_data[31 - 8*bsel_q -: 8]};
				st_d = swse_pkg::SWSE_WAIT;
			end
			swse_pkg::SWSE_WAIT:
			if (st_ready)
			begin
				req_d.valid = 1'b0;
				st_d = swse_pkg::SWSE_IDLE;
				busy_d = 1'b0;
				if (op_q == swse_pkg::SWSE_OP_STRING)
				begin
					left_d = left_q - 7'h01;
					raddr_d = raddr_q + 32'h1;
					bsel_d = bsel_q + 2'h1;
					if (bsel_q == 2'h3)
						reg_d = reg_q + 5'h01;
					if (left_q != 7'h01)
					begin
						st_d = swse_pkg::SWSE_EMIT;
						busy_d = 1'b1;
					end
				end
			end
			default: st_d = swse_pkg::SWSE_IDLE;
		endcase
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			b_q <= 1'b0;
			awa_q <= 8'h00;
			wd_q <= 32'h0;
			bresp_q <= 2'h0;
			r_q <= 1'b0;
			rd_q <= 32'h0;
			rresp_q <= 2'h0;
			insn_q <= 32'h0;
			src_q <= 32'h0;
			base_q <= 32'h0;
			idx_q <= 32'h0;
			xer_q <= 32'h0;
			resv_q <= 1'b0;
			mq_q <= 1'b0;
			st_q <= swse_pkg::SWSE_IDLE;
			op_q <= swse_pkg::SWSE_OP_NONE;
			left_q <= 7'h00;
			bsel_q <= 2'h0;
			reg_q <= 5'h00;
			req_q <= '0;
			busy_q <= 1'b0;
			cr0_q <= 4'h0;
			laddr_q <= 32'h0;
			ldata_q <= 32'h0;
			raddr_q <= 32'h0;
		end
		else
		begin
			aw_q <= aw_d;
			w_q <= w_d;
			b_q <= b_d;
			awa_q <= awa_d;
			wd_q <= wd_d;
			bresp_q <= bresp_d;
			r_q <= r_d;
			rd_q <= rd_d;
			rresp_q <= rresp_d;
			insn_q <= insn_d;
			src_q <= src_d;
			base_q <= base_d;
			idx_q <= idx_d;
			xer_q <= xer_d;
			resv_q <= resv_d;
			mq_q <= mq_d;
			st_q <= st_d;
			op_q <= op_d;
			left_q <= left_d;
			bsel_q <= bsel_d;
			reg_q <= reg_d;
			req_q <= req_d;
			busy_q <= busy_d;
			cr0_q <= cr0_d;
			laddr_q <= laddr_d;
			ldata_q <= ldata_d;
			raddr_q <= raddr_d;
		end
	end

	// ==========================================================
	// assertions
	string_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_q == swse_pkg::SWSE_IDLE && go && dec == swse_pkg::SWSE_OP_STRING)
		|=> left_q == $past(cnt))
		else $error("string byte count not taken from exception register");
	cond_noresv_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_q == swse_pkg::SWSE_IDLE && go && dec == swse_pkg::SWSE_OP_COND && !resv_q)
		|=> !req_q.valid && cr0_q[1] == 1'b0)
		else $error("conditional store wrote without a reservation");
	cond_ok_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_q == swse_pkg::SWSE_IDLE && go && dec == swse_pkg::SWSE_OP_COND && resv_q)
		|=> req_q.valid && !resv_q && cr0_q[3:1] == 3'b001)
		else $error("conditional store success not reported");
	cr0_so_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_q == swse_pkg::SWSE_IDLE && go && dec == swse_pkg::SWSE_OP_COND)
		|=> cr0_q[0] == $past(xer_q[`SWSE_XER_SO]))
		else $error("summary overflow not copied");
	cr0_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(go && dec != swse_pkg::SWSE_OP_COND) |=> $stable(cr0_q))
		else $error("field zero changed by plain store");
	brev_data_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_q == swse_pkg::SWSE_IDLE && go && dec == swse_pkg::SWSE_OP_BREV)
		|=> req_q.data == {$past(src_q[7:0]), $past(src_q[15:8]), $past(src_q[23:16]),
			$past(src_q[31:24])})
		else $error("byte-reversed data wrong");
	disp_addr_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_q == swse_pkg::SWSE_IDLE && go && dec == swse_pkg::SWSE_OP_DISP)
		|=> req_q.addr == $past(ea) && req_q.data == $past(src_q))
		else $error("displacement store address or data wrong");
	req_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(req_q.valid && !st_ready) |=> $stable(req_q))
		else $error("store request changed while stalled");
	resv_snoop_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_fire && awa_q == `SWSE_OFF_SNOOP) |=> !resv_q)
		else $error("reservation survived a foreign write");
	cov_string_c: cover property (@(posedge aclk) go && dec == swse_pkg::SWSE_OP_STRING);
	cov_cond_ok_c: cover property (@(posedge aclk) go && dec == swse_pkg::SWSE_OP_COND && resv_q);
	cov_cond_fail_c: cover property (@(posedge aclk) go && dec == swse_pkg::SWSE_OP_COND && !resv_q);
endmodule // swse_exec

// ### bench/swse_store_model.sv
// Purpose: storage and register file partner for swse_exec
// Assumes: register n holds a fixed pattern built from n
// Notes: slow mode accepts a store only every third cycle
`timescale 1ns/10ps
module swse_store_model
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic slow,
	input wire logic [4:0] regfile_idx,
	output logic [31:0] regfile_data,
	input wire swse_pkg::swse_store_t st_req,
	output logic st_ready
);
	logic [31:0] pa [64];
	logic [31:0] pd [64];
	logic [3:0] ps [64];
	int pn;
	logic [1:0] cnt_q;
	// distinct bytes per register so a wrong lane or register shows up
	assign regfile_data = {3'h1, regfile_idx, 3'h2, regfile_idx,
		3'h3, regfile_idx, 3'h4, regfile_idx};
	assign st_ready = !slow || (cnt_q == 2'h2);
	// =====================================================
	// store log
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt_q <= 2'h0;
			pn <= 0;
		end
		else
		begin
			cnt_q <= (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
			if (st_req.valid && st_ready)
			begin
				pa[pn[5:0]] <= st_req.addr;
				pd[pn[5:0]] <= st_req.data;
				ps[pn[5:0]] <= st_req.strb;
				pn <= pn + 1;
			end
		end
	end
endmodule // swse_store_model

// ### bench/store_word_string_exec_test.sv
// Purpose: self-checking bench for swse_exec
// Assumes: axi4-lite master tasks, partner logs every accepted store
// Notes: watchdog ends a hang through conclude
`timescale 1ns/10ps
`include "swse_map.svh"
module store_word_string_exec_test;
	logic aclk = 1'b0, aresetn = 1'b0, slow = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, regfile_data;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [4:0] regfile_idx;
	swse_pkg::swse_store_t st_req;
	logic st_ready, mq_undef;
	logic [31:0] v, c0;
	int n_fail = 0, n_checks = 0, n0, j;
	swse_exec swse_exec_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .regfile_idx,
		.regfile_data, .st_req, .st_ready, .mq_undef);
	swse_store_model swse_store_model_i (.aclk, .aresetn, .slow, .regfile_idx, .regfile_data,
		.st_req, .st_ready);
	initial
	begin
		forever #2.5 aclk = ~aclk;
	end
	// =====================================================
	// bus tasks
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// no cycle budget here: only the watchdog may end a wait
		do
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask
	function automatic logic [31:0] general_regfile(input logic [4:0] r);
		return {3'h1, r, 3'h2, r, 3'h3, r, 3'h4, r};
	endfunction
	function automatic logic [31:0] mk(input logic [5:0] p, input logic [4:0] s,
		input logic [4:0] b, input logic [15:0] lo);
		return {p, s, b, lo};
	endfunction
	// busy is polled because string length sets the run time
	task automatic run(input logic [31:0] insn, input logic [31:0] src, input logic [31:0] base,
		input logic [31:0] idx, input logic [31:0] fixed_exception_reg);
		n0 = swse_store_model_i.pn;
		axw(`SWSE_OFF_INSN, insn);
		axw(`SWSE_OFF_SRC, src);
		axw(`SWSE_OFF_BASE, base);
		axw(`SWSE_OFF_INDEX, idx);
		axw(`SWSE_OFF_XER, fixed_exception_reg);
		axw(`SWSE_OFF_CTRL, 32'h1);
		do
			axr(`SWSE_OFF_STAT, v);
		while (v[0] !== 1'b0);
	endtask
	task automatic chk_str(input int cnt, input logic [31:0] ea, input logic [4:0] s);
		logic [7:0] b;
		logic [31:0] a;
		chk("count", cnt, swse_store_model_i.pn - n0);
		for (int k = 0; k < cnt; k++)
		begin
			b = 8'(general_regfile(5'(s + k / 4)) >> (24 - 8 * (k % 4)));
			a = ea + k;
			chk("addr", a, swse_store_model_i.pa[n0 + k]);
			chk("data", {4{b}}, swse_store_model_i.pd[n0 + k]);
			chk("strb", 4'h8 >> a[1:0], swse_store_model_i.ps[n0 + k]);
		end
	endtask
	task automatic chk_word(input int cnt, input logic [31:0] ea, input logic [31:0] d);
		chk("count", cnt, swse_store_model_i.pn - n0);
		if (cnt == 0) return;
		chk("addr", ea, swse_store_model_i.pa[n0]);
		chk("data", d, swse_store_model_i.pd[n0]);
		chk("strb", 4'hF, swse_store_model_i.ps[n0]);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		#200000;
		n_fail++;
		conclude();
	end
	// =====================================================
	// tests
	initial
	begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		axr(`SWSE_OFF_CR0, c0);
		run(mk(`SWSE_OP_PRIMARY, 5'd6, 5'd4, {5'd5, `SWSE_XO_STSWX, 1'b0}), 0, 32'h1000, 7, 32'h186);
		chk_str(6, 32'h1007, 5'd6);
		chk("mq", 1'b1, mq_undef);
		axr(`SWSE_OFF_XER, v);
		chk("xer", 32'h186, v);
		axw(`SWSE_OFF_CTRL, 32'h4);
		chk("mq clr", 1'b0, mq_undef);
		slow <= 1'b0;
		run(mk(`SWSE_OP_PRIMARY, 5'd29, 5'd0, {5'd5, `SWSE_XO_STSWX, 1'b0}), 0, 32'h5555, 32'h2002, 9);
		chk_str(9, 32'h2002, 5'd29);
		run(mk(`SWSE_OP_PRIMARY, 5'd6, 5'd4, {5'd5, `SWSE_XO_STSWX, 1'b0}), 0, 32'h10, 4, 32'h80);
		chk_str(0, 32'h14, 5'd6);
		$display("test string done");
		for (j = 0; j < 2; j++)
		begin
			run(mk(`SWSE_OP_STW, 5'd3, j ? 5'd1 : 5'd0, 16'hFFFC), 32'hDEADBEEF, 32'h2000, 0, 0);
			chk_word(1, j ? 32'h1FFC : 32'hFFFFFFFC, 32'hDEADBEEF);
			run(mk(`SWSE_OP_PRIMARY, 5'd3, j ? 5'd2 : 5'd0, {5'd1, `SWSE_XO_STWBRX, 1'b0}),
				32'h12345678, 32'h100, 32'h20, 0);
			chk_word(1, j ? 32'h120 : 32'h20, 32'h78563412);
			axr(`SWSE_OFF_ADDR, v);
			chk("last addr", j ? 32'h120 : 32'h20, v);
			axr(`SWSE_OFF_WDATA, v);
			chk("last data", 32'h78563412, v);
		end
		axr(`SWSE_OFF_CR0, v);
		chk("cr0 kept", c0, v);
		$display("test word done");
		// cases: no reservation, reservation, reservation lost to a snoop write
		for (j = 0; j < 3; j++)
		begin
			if (j > 0) axw(`SWSE_OFF_CTRL, 32'h2);
			if (j == 2) axw(`SWSE_OFF_SNOOP, 32'h0);
			run(mk(`SWSE_OP_PRIMARY, 5'd3, 5'd2, {5'd1, `SWSE_XO_STWCX, 1'b1}),
				32'hA5A50F0F, 32'h300, 32'h40, j == 2 ? 32'h0 : 32'h80000000);
			chk_word(j == 1, 32'h340, 32'hA5A50F0F);
			axr(`SWSE_OFF_CR0, v);
			chk("cr0", {j == 1, j != 2}, v[3:0]);
			axr(`SWSE_OFF_STAT, v);
			chk("resv", 1'b0, v[1]);
			axr(`SWSE_OFF_XER, v);
			chk("xer so", j == 2 ? 32'h0 : 32'h80000000, v);
			// a plain store after a success must leave a nonzero field zero alone
			if (j == 1)
			begin
				run(mk(`SWSE_OP_STW, 5'd3, 5'd0, 16'h0040), 32'h1, 32'h0, 0, 32'h80000000);
				axr(`SWSE_OFF_CR0, v);
				chk("cr0 kept", 32'h3, v);
			end
		end
		$display("test conditional done");
		axr(8'h3C, v);
		chk("rd resp", `SWSE_RESP_SLVERR, rsp);
		chk("rd data", 32'h0, v);
		axw(8'h3C, 32'h1);
		chk("wr resp", `SWSE_RESP_SLVERR, rsp);
		// an undecodable instruction word must not reach storage
		run(32'h0, 32'h1, 32'h40, 32'h40, 0);
		chk_word(0, 32'h80, 32'h1);
		$display("test unmapped done");
		conclude();
	end
endmodule // store_word_string_exec_test
